// ### design/rtcpt_map.svh
// Purpose: named constants of the tick timer block
// Assumes: included by the package and the top module
// Notes: widths, bit positions and reset values
`ifndef RTCPT_MAP_SVH
`define RTCPT_MAP_SVH
`define RTCPT_PRESC_W 15
`define RTCPT_CNT_W 16
`define RTCPT_DIV_W 4
`define RTCPT_SEL_W 2
`define RTCPT_NSRC 4
`define RTCPT_NEVT 8
`define RTCPT_NFLAG 3
`define RTCPT_EVT_TOP_BIT 12
`define RTCPT_PIT_SEL_MIN 4'h1
`define RTCPT_PIT_SEL_MAX 4'hE
`define RTCPT_SIXTEEN_SEL 4'h3
`define RTCPT_SIXTEEN_BIT 3
`define RTCPT_EVT7_BIT 5
`define RTCPT_FLAG_WRAP 0
`define RTCPT_FLAG_MATCH 1
`define RTCPT_FLAG_PIT 2
`define RTCPT_VEC_COUNTER 8'h00
`define RTCPT_VEC_PERIODIC 8'h02
`define RTCPT_DIV_RESET 4'h0
`define RTCPT_SEL_RESET 4'h0
`define RTCPT_CNT_RESET 16'h0000
`define RTCPT_PRESC_RESET 15'h0000
`define RTCPT_PRESC_ONE 15'h0001
`define RTCPT_PRESC_ONES 15'h7FFF
`define RTCPT_CNT_ONE 16'h0001
`endif

// ### design/rtcpt_pkg.sv
// Purpose: types of the tick timer block
// Assumes: rtcpt_map.svh holds the numbers
// Notes: none
`include "rtcpt_map.svh"
package rtcpt_pkg;
  typedef enum logic [1:0] {
    RTCPT_SRC_CRYSTAL = 2'b00,
    RTCPT_SRC_EXTCLK = 2'b01,
    RTCPT_SRC_ULP = 2'b10,
    RTCPT_SRC_ULP_DIV = 2'b11
  } rtcpt_src_type;
  typedef enum logic [1:0] {
    RTCPT_XFER_IDLE = 2'b00,
    RTCPT_XFER_WAIT = 2'b01,
    RTCPT_XFER_HALF = 2'b10
  } rtcpt_xfer_type;
endpackage

// ### design/rtcpt_sync.sv
// Purpose: two flip-flop synchroniser for one level
// Assumes: input is asynchronous to clk
// Notes: the first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module rtcpt_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### design/rtcpt_top.sv
// Purpose: real-time counter and periodic tick timer on a shared prescaler
// Assumes: clk 10 MHz; reference sources at most a quarter of clk
// Notes: configuration arrives as plain same-clock ports with write strobes
`timescale 1ns/10ps
`default_nettype none
`include "rtcpt_map.svh"
module rtcpt_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`RTCPT_NSRC-1:0] ref_src,
  input wire rtcpt_pkg::rtcpt_src_type source_select,
  input wire logic cpu_halted,
  input wire logic counter_run_when_halted,
  input wire logic pit_run_when_halted,
  input wire logic ctrl_write,
  input wire logic counter_enable_bit,
  input wire logic [`RTCPT_DIV_W-1:0] divide_setting,
  input wire logic pit_write,
  input wire logic periodic_enable_bit,
  input wire logic [`RTCPT_DIV_W-1:0] period_select,
  input wire logic [`RTCPT_CNT_W-1:0] compare_value,
  input wire logic [`RTCPT_CNT_W-1:0] period_value,
  input wire logic wrap_irq_enable,
  input wire logic match_irq_enable,
  input wire logic periodic_irq_enable,
  input wire logic [`RTCPT_NFLAG-1:0] flag_clear,
  output logic control_sync_pending,
  output logic pit_sync_pending,
  output logic [`RTCPT_CNT_W-1:0] count_value,
  output logic [`RTCPT_NFLAG-1:0] irq_flags,
  output logic counter_irq,
  output logic periodic_irq,
  output logic wrap_event,
  output logic match_event,
  output logic pit_wave,
  output logic [`RTCPT_NEVT-1:0] pit_event
);
  import rtcpt_pkg::*;

  // ************************************************************
  // reference clock selection and edge detect
  // ************************************************************
  logic [`RTCPT_NSRC-1:0] src_sync;
  logic ref_level_reg;
  logic ref_tick;

  genvar gi;
  generate
    for (gi = 0; gi < `RTCPT_NSRC; gi = gi + 1) begin : g_src
      rtcpt_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(ref_src[gi]),
        .sync_out(src_sync[gi])
      );
    end
  endgenerate

  // one source serves both functions
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_level_reg <= 1'b0;
    end else begin
      ref_level_reg <= src_sync[source_select];
    end
  end

  // a source switch may give one spurious tick; software changes it idle
  assign ref_tick = src_sync[source_select] & ~ref_level_reg;

  // ************************************************************
  // control transfer into the reference domain
  // ************************************************************
  rtcpt_xfer_type ctrl_state_reg;
  rtcpt_xfer_type pit_state_reg;
  logic ctrl_en_shadow_reg;
  logic [`RTCPT_DIV_W-1:0] div_shadow_reg;
  logic pit_en_shadow_reg;
  logic [`RTCPT_DIV_W-1:0] sel_shadow_reg;
  logic rtc_en_reg;
  logic [`RTCPT_DIV_W-1:0] div_reg;
  logic pit_en_reg;
  logic [`RTCPT_DIV_W-1:0] sel_reg;

  // a new write restarts the transfer so the latest value wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_state_reg <= RTCPT_XFER_IDLE;
      ctrl_en_shadow_reg <= 1'b0;
      div_shadow_reg <= `RTCPT_DIV_RESET;
      rtc_en_reg <= 1'b0;
      div_reg <= `RTCPT_DIV_RESET;
    end else if (ctrl_write) begin
      ctrl_state_reg <= RTCPT_XFER_WAIT;
      ctrl_en_shadow_reg <= counter_enable_bit;
      div_shadow_reg <= divide_setting;
    end else if (ref_tick) begin
      case (ctrl_state_reg)
        RTCPT_XFER_WAIT: begin
          ctrl_state_reg <= RTCPT_XFER_HALF;
        end
        RTCPT_XFER_HALF: begin
          ctrl_state_reg <= RTCPT_XFER_IDLE;
          rtc_en_reg <= ctrl_en_shadow_reg;
          div_reg <= div_shadow_reg;
        end
        default: begin
          ctrl_state_reg <= RTCPT_XFER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pit_state_reg <= RTCPT_XFER_IDLE;
      pit_en_shadow_reg <= 1'b0;
      sel_shadow_reg <= `RTCPT_SEL_RESET;
      pit_en_reg <= 1'b0;
      sel_reg <= `RTCPT_SEL_RESET;
    end else if (pit_write) begin
      pit_state_reg <= RTCPT_XFER_WAIT;
      pit_en_shadow_reg <= periodic_enable_bit;
      sel_shadow_reg <= period_select;
    end else if (ref_tick) begin
      case (pit_state_reg)
        RTCPT_XFER_WAIT: begin
          pit_state_reg <= RTCPT_XFER_HALF;
        end
        RTCPT_XFER_HALF: begin
          pit_state_reg <= RTCPT_XFER_IDLE;
          pit_en_reg <= pit_en_shadow_reg;
          sel_reg <= sel_shadow_reg;
        end
        default: begin
          pit_state_reg <= RTCPT_XFER_IDLE;
        end
      endcase
    end
  end

  assign control_sync_pending = (ctrl_state_reg != RTCPT_XFER_IDLE);
  assign pit_sync_pending = (pit_state_reg != RTCPT_XFER_IDLE);

  // ************************************************************
  // shared prescaler
  // ************************************************************
  logic rtc_run;
  logic pit_run;
  logic presc_on;
  logic presc_step;
  logic [`RTCPT_PRESC_W-1:0] presc_reg;
  logic [`RTCPT_PRESC_W-1:0] div_mask;
  logic count_tick;

  assign rtc_run = rtc_en_reg & (~cpu_halted | counter_run_when_halted);
  assign pit_run = pit_en_reg & (~cpu_halted | pit_run_when_halted);
  assign presc_on = rtc_en_reg | pit_en_reg;
  assign presc_step = ref_tick & (rtc_run | pit_run);

  // both enables off clears the count so a cold start begins at zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      presc_reg <= `RTCPT_PRESC_RESET;
    end else if (!presc_on) begin
      presc_reg <= `RTCPT_PRESC_RESET;
    end else if (presc_step) begin
      presc_reg <= presc_reg + `RTCPT_PRESC_ONE;
    end
  end

  assign div_mask = ~(`RTCPT_PRESC_ONES << div_reg);
  assign count_tick = ref_tick & rtc_run &
    ((presc_reg & div_mask) == div_mask);

  // ************************************************************
  // real-time counter
  // ************************************************************
  logic wrap_hit;
  logic match_hit;

  assign wrap_hit = count_tick && (count_value == period_value);
  assign match_hit = count_tick && (count_value == compare_value);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_value <= `RTCPT_CNT_RESET;
    end else if (wrap_hit) begin
      count_value <= `RTCPT_CNT_RESET;
    end else if (count_tick) begin
      count_value <= count_value + `RTCPT_CNT_ONE;
    end
  end

  // strobes last until the next reference edge, one reference cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrap_event <= 1'b0;
      match_event <= 1'b0;
    end else if (ref_tick) begin
      wrap_event <= wrap_hit;
      match_event <= match_hit;
    end
  end

  // ************************************************************
  // periodic timer and event waves
  // ************************************************************
  logic sel_valid;
  logic pit_wave_next;
  logic pit_rise;

  assign sel_valid = (sel_reg >= `RTCPT_PIT_SEL_MIN) &&
    (sel_reg <= `RTCPT_PIT_SEL_MAX);
  // select n taps bit n: period two to the n plus one cycles
  assign pit_wave_next = pit_run & sel_valid & presc_reg[sel_reg];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pit_wave <= 1'b0;
    end else begin
      pit_wave <= pit_wave_next;
    end
  end

  assign pit_rise = pit_wave_next & ~pit_wave;

  generate
    for (gi = 0; gi < `RTCPT_NEVT; gi = gi + 1) begin : g_evt
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pit_event[gi] <= 1'b0;
        end else begin
          pit_event[gi] <= pit_run & presc_reg[`RTCPT_EVT_TOP_BIT-gi];
        end
      end
    end
  endgenerate

  // ************************************************************
  // flags and requests
  // ************************************************************
  logic [`RTCPT_NFLAG-1:0] flag_set;

  assign flag_set[`RTCPT_FLAG_WRAP] = wrap_hit;
  assign flag_set[`RTCPT_FLAG_MATCH] = match_hit;
  assign flag_set[`RTCPT_FLAG_PIT] = pit_rise;

  // a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_flags <= '0;
    end else begin
      irq_flags <= (irq_flags & ~flag_clear) | flag_set;
    end
  end

  // counter line answers vector 0x00, periodic line vector 0x02
  assign counter_irq =
    (irq_flags[`RTCPT_FLAG_WRAP] & wrap_irq_enable) |
    (irq_flags[`RTCPT_FLAG_MATCH] & match_irq_enable);
  assign periodic_irq =
    irq_flags[`RTCPT_FLAG_PIT] & periodic_irq_enable;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_ctrl_last_tick;
    ctrl_state_reg == RTCPT_XFER_HALF && ref_tick && !ctrl_write;
  endsequence

  sequence s_ctrl_applied;
    !control_sync_pending && div_reg == $past(div_shadow_reg);
  endsequence

  a_busy_on_write: assert property (
    ctrl_write |=> control_sync_pending)
    else $error("sync pending not raised after write");

  a_div_two_ticks: assert property (
    s_ctrl_last_tick |=> s_ctrl_applied)
    else $error("divider not applied on second reference edge");

  a_presc_cold: assert property (
    !presc_on |=> presc_reg == `RTCPT_PRESC_RESET)
    else $error("prescaler not held at zero while both disabled");

  a_halt_freeze: assert property (
    cpu_halted && !counter_run_when_halted && !pit_run_when_halted
    |=> $stable(presc_reg) || !presc_on)
    else $error("prescaler moved while cpu halted");

  a_wrap_clears: assert property (
    wrap_hit |=> count_value == `RTCPT_CNT_RESET &&
    irq_flags[`RTCPT_FLAG_WRAP])
    else $error("wrap did not clear counter and set flag");

  a_pit_sixteen: assert property (
    pit_run && sel_reg == `RTCPT_SIXTEEN_SEL
    |=> pit_wave == $past(presc_reg[`RTCPT_SIXTEEN_BIT]))
    else $error("sixteen-cycle wave not on prescaler bit 3");

  a_event_seven: assert property (
    pit_run |=>
    pit_event[`RTCPT_NEVT-1] == $past(presc_reg[`RTCPT_EVT7_BIT]))
    else $error("event 7 not a 64-cycle wave");

  a_irq_hold: assert property (
    periodic_irq && !flag_clear[`RTCPT_FLAG_PIT]
    |=> periodic_irq || !periodic_irq_enable)
    else $error("periodic request dropped before flag clear");

  a_match_strobe: assert property (
    match_hit |=> ##[0:40] match_event)
    else $error("match strobe missing");
endmodule
`default_nettype wire

// ### test/rtcpt_ref_model.sv
// Purpose: slow reference oscillators that feed the tick timer
// Assumes: oscillators run free, as crystal and rc sources do
// Notes: source n has period 800 ns times two to the n
`timescale 1ns/10ps
`default_nettype none
module rtcpt_ref_model #(
  parameter int HALF0 = 400
) (
  output logic [3:0] ref_src
);
  // ****************
  // oscillators
  // ****************
  // odd start offset keeps ref edges off clk edges, so counts stay exact
  initial begin
    ref_src = 4'h0;
    #37;
    forever begin
      #(HALF0);
      ref_src = ref_src + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### test/tb_rtc_periodic_tick_timer.sv
// Purpose: self-checking bench for the tick timer block
// Assumes: clk 100 ns; ref sources from rtcpt_ref_model
// Notes: gaps are counted in edges of the selected ref source
`timescale 1ns/10ps
`default_nettype none
module tb_rtc_periodic_tick_timer;
  import rtcpt_pkg::*;
  logic clk, rstn, cpu_halted, counter_run_when_halted, pit_run_when_halted;
  logic ctrl_write, counter_enable_bit, pit_write, periodic_enable_bit;
  logic wrap_irq_enable, match_irq_enable, periodic_irq_enable, ref_q;
  logic control_sync_pending, pit_sync_pending, counter_irq, periodic_irq;
  logic wrap_event, match_event, pit_wave;
  logic [3:0] ref_src, divide_setting, period_select;
  logic [15:0] compare_value, period_value, count_value, c;
  logic [2:0] flag_clear, irq_flags;
  logic [7:0] pit_event;
  rtcpt_src_type source_select;
  int n_mismatch, check_count, cycles, ref_cnt, hi, per, n;
  rtcpt_ref_model refs (.ref_src(ref_src));
  rtcpt_top dut (.clk(clk), .rstn(rstn), .ref_src(ref_src),
    .source_select(source_select), .cpu_halted(cpu_halted),
    .counter_run_when_halted(counter_run_when_halted),
    .pit_run_when_halted(pit_run_when_halted), .ctrl_write(ctrl_write),
    .counter_enable_bit(counter_enable_bit), .divide_setting(divide_setting),
    .pit_write(pit_write), .periodic_enable_bit(periodic_enable_bit),
    .period_select(period_select), .compare_value(compare_value),
    .period_value(period_value), .wrap_irq_enable(wrap_irq_enable),
    .match_irq_enable(match_irq_enable),
    .periodic_irq_enable(periodic_irq_enable), .flag_clear(flag_clear),
    .control_sync_pending(control_sync_pending),
    .pit_sync_pending(pit_sync_pending), .count_value(count_value),
    .irq_flags(irq_flags), .counter_irq(counter_irq),
    .periodic_irq(periodic_irq), .wrap_event(wrap_event),
    .match_event(match_event), .pit_wave(pit_wave), .pit_event(pit_event));
  // ****************
  // clock, timeout and ref edge count
  // ****************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    ref_q <= ref_src[source_select];
    if (ref_src[source_select] && !ref_q) begin
      ref_cnt <= ref_cnt + 1;
    end
    if (cycles == 90000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  function automatic logic sig(int k);
    if (k == 0) return pit_wave;
    if (k == 1) return wrap_event;
    if (k == 2) return match_event;
    return pit_event[k-3];
  endfunction
  task automatic wait_lvl(int k, logic v);
    int w;
    w = 0;
    while (sig(k) !== v && w < 70000) begin
      step(1);
      w++;
    end
  endtask
  // gap in ref edges from a rise to the fall and to the next rise
  task automatic rise_gap(int k);
    int t0;
    wait_lvl(k, 1'b0);
    wait_lvl(k, 1'b1);
    t0 = ref_cnt;
    wait_lvl(k, 1'b0);
    hi = ref_cnt - t0;
    wait_lvl(k, 1'b1);
    per = ref_cnt - t0;
  endtask
  task automatic wait_idle();
    int w;
    w = 0;
    while ((control_sync_pending | pit_sync_pending) !== 1'b0 &&
      w < 1000) begin
      step(1);
      w++;
    end
  endtask
  task automatic wr(logic periodic_tick_timer, logic en, logic [3:0] f);
    logic p;
    wait_idle();
    pit_write = periodic_tick_timer;
    ctrl_write = !periodic_tick_timer;
    if (periodic_tick_timer) begin
      periodic_enable_bit = en;
      period_select = f;
    end else begin
      counter_enable_bit = en;
      divide_setting = f;
    end
    step(1);
    pit_write = 1'b0;
    ctrl_write = 1'b0;
    p = periodic_tick_timer ? pit_sync_pending : control_sync_pending;
    check("pending", 16'(p), 16'h0001);
    wait_idle();
    p = pit_sync_pending | control_sync_pending;
    check("pending low", 16'(p), 16'h0000);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_cold_pit();
    check("reset flags", 16'(irq_flags), 16'h0000);
    check("reset count", count_value, 16'h0000);
    periodic_irq_enable = 1'b1;
    n = ref_cnt;
    wr(1'b1, 1'b1, 4'h3);
    wait_lvl(0, 1'b1);
    n = ref_cnt - n;
    check("first rise", 16'(n >= 8 && n <= 12), 16'h0001);
    step(2);
    check("pit flag", 16'(irq_flags[2]), 16'h0001);
    check("pit irq", 16'(periodic_irq), 16'h0001);
    rise_gap(0);
    check("wave high", 16'(hi), 16'h0008);
    check("wave period", 16'(per), 16'h0010);
    $display("test cold_pit done");
  endtask
  task automatic t_sources();
    for (int s = 3; s >= 0; s--) begin
      source_select = rtcpt_src_type'(s);
      rise_gap(0);
      rise_gap(0);
      check("source period", 16'(per), 16'h0010);
    end
    $display("test sources done");
  endtask
  task automatic t_events();
    for (int i = 3; i < 8; i++) begin
      rise_gap(3 + i);
      check("event period", 16'(per), 16'(8192 >> i));
      check("event high", 16'(hi), 16'(4096 >> i));
    end
    wr(1'b1, 1'b1, 4'h1);
    rise_gap(0);
    check("short period", 16'(per), 16'h0004);
    cpu_halted = 1'b1;
    step(3);
    c = 16'(pit_wave);
    hi = 0;
    repeat (40) begin
      step(1);
      hi += (pit_wave !== c[0]);
    end
    check("halted wave", 16'(hi), 16'h0000);
    pit_run_when_halted = 1'b1;
    rise_gap(0);
    check("wave when halted", 16'(per), 16'h0004);
    cpu_halted = 1'b0;
    pit_run_when_halted = 1'b0;
    wr(1'b1, 1'b0, 4'h1);
    // the wave register follows the applied enable one clock later
    step(1);
    c = 16'(pit_wave);
    step(80);
    check("pit stopped", 16'(pit_wave), c);
    check("pit irq held", 16'(periodic_irq), 16'h0001);
    flag_clear = 3'b100;
    step(1);
    flag_clear = 3'b000;
    check("pit irq cleared", 16'(periodic_irq), 16'h0000);
    $display("test events done");
  endtask
  task automatic t_counter();
    compare_value = 16'h0003;
    period_value = 16'h0005;
    match_irq_enable = 1'b1;
    wr(1'b0, 1'b1, 4'h0);
    rise_gap(1);
    check("wrap strobe", 16'(hi), 16'h0001);
    check("wrap period", 16'(per), 16'h0006);
    rise_gap(2);
    check("match strobe", 16'(hi), 16'h0001);
    check("match period", 16'(per), 16'h0006);
    c = 16'h0000;
    repeat (100) begin
      step(1);
      if (count_value > c) c = count_value;
    end
    check("count top", c, 16'h0005);
    wr(1'b0, 1'b1, 4'h2);
    rise_gap(1);
    check("divided period", 16'(per), 16'h0018);
    cpu_halted = 1'b1;
    step(3);
    c = count_value;
    step(100);
    check("halted count", count_value, c);
    counter_run_when_halted = 1'b1;
    step(100);
    check("run when halted", 16'(count_value !== c), 16'h0001);
    cpu_halted = 1'b0;
    wr(1'b0, 1'b0, 4'h2);
    c = count_value;
    step(100);
    check("counter stopped", count_value, c);
    check("wrap flag", 16'(irq_flags[0]), 16'h0001);
    check("match irq", 16'(counter_irq), 16'h0001);
    flag_clear = 3'b010;
    step(1);
    flag_clear = 3'b000;
    check("irq after clear", 16'(counter_irq), 16'h0000);
    wrap_irq_enable = 1'b1;
    step(1);
    check("wrap irq", 16'(counter_irq), 16'h0001);
    flag_clear = 3'b001;
    step(1);
    flag_clear = 3'b000;
    check("wrap irq cleared", 16'(counter_irq), 16'h0000);
    $display("test counter done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rstn, cpu_halted, counter_run_when_halted, pit_run_when_halted} = 4'h0;
    {ctrl_write, counter_enable_bit, pit_write, periodic_enable_bit} = 4'h0;
    {wrap_irq_enable, match_irq_enable, periodic_irq_enable} = 3'b000;
    divide_setting = 4'h0;
    period_select = 4'h0;
    compare_value = 16'h0000;
    period_value = 16'h0000;
    flag_clear = 3'b000;
    source_select = RTCPT_SRC_CRYSTAL;
    {n_mismatch, check_count, cycles, ref_cnt} = '0;
    ref_q = 1'b0;
    step(12);
    rstn = 1'b1;
    step(1);
    t_cold_pit();
    t_sources();
    t_events();
    t_counter();
    complete_run();
  end
endmodule
`default_nettype wire
